/* pkg/cksd_defines.svh */
// Register offsets, field positions, reset values and timing constants of the clock slice
`ifndef CKSD_DEFINES_SVH
`define CKSD_DEFINES_SVH
// ==========================================
// Register byte offsets inside the 2-Kbyte window
`define CKSD_OFF_DIV 11'h000
`define CKSD_OFF_RCTL 11'h004
`define CKSD_OFF_RFLG 11'h008
`define CKSD_OFF_WCTL 11'h00c
`define CKSD_OFF_WSVC 11'h010
`define CKSD_OFF_BASE 11'h014
// ==========================================
// Field positions
`define CKSD_RCTL_EN 7
`define CKSD_RCTL_HW 6
`define CKSD_RCTL_HD 5
`define CKSD_RCTL_BYP 3
`define CKSD_RFLG_FLAG 7
`define CKSD_WCTL_CME 7
// ==========================================
// Reset values and service codes
`define CKSD_BASE_RST 21'h000000
`define CKSD_SVC_ARM 8'h55
`define CKSD_SVC_DONE 8'haa
// ==========================================
// Divider chain stages: normal chain 2^12, bypassed chain 2^1
`define CKSD_CHAIN_NORM 5'h0c
`define CKSD_CHAIN_BYP 5'h01
`endif

/* pkg/cksd_pkg.sv */
// Types of the clock, periodic interrupt and watchdog slice
package cksd_pkg;
  typedef logic [2:0] cksd_sel_t;
  typedef struct packed {
    cksd_sel_t div_sel;
    logic rti_en;
    logic halt_wait;
    logic halt_dbg;
    logic bypass;
    cksd_sel_t rti_rate;
    logic rti_flag;
    cksd_sel_t wd_rate;
    logic clk_monitor_enable;
    logic hw_lock;
    logic hd_lock;
    logic wd_lock;
    logic wd_armed;
    logic [20:0] base;
    logic [7:0] slow_cnt;
    logic fix_tick;
    logic bus_tick;
    logic [3:0] cpu_clk;
    logic [19:0] rti_cnt;
    logic [23:0] wd_cnt;
    logic rst_req;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cksd_state_t;
endpackage : cksd_pkg

/* rtl/cksd_top.sv */
// Clock generation, slow divider, periodic interrupt, watchdog and clock monitor
`timescale 1ns/1ps
`include "cksd_defines.svh"
module cksd_top (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Operating modes
  input wire logic wait_mode,
  input wire logic debug_mode,
  input wire logic special_mode,
  // RC clock monitor cell, high when no edges seen within its window
  input wire logic rc_no_edge,
  // Clock enables
  output logic bus_clk_en,
  output logic wait_fixed_clk_en,
  output logic [3:0] cpu_clk,
  // Interrupt and reset request
  output logic periodic_irq,
  output logic sys_reset_req
);
  import cksd_pkg::*;

  // ==========================================
  // Reset release
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================
  // State
  cksd_state_t s_q;
  cksd_state_t s_d;

  logic hit;
  logic wr;
  logic [10:0] off;
  logic [7:0] wb;
  logic [8:0] gmask;
  logic [7:0] hmask;
  logic gtick;
  logic run;
  logic [4:0] rexp;
  logic [4:0] wexp;
  logic [19:0] rmask;
  logic [23:0] wmask;

  // Watchdog stage count above the common chain (2^12, or 2^1 when bypassed)
  function automatic logic [4:0] cksd_wd_exp(input cksd_sel_t r);
    logic [4:0] e;
    e = 5'h00;
    unique case (r)
      3'h1: e = 5'h01;
      3'h2: e = 5'h03;
      3'h3: e = 5'h05;
      3'h4: e = 5'h07;
      3'h5: e = 5'h09;
      3'h6: e = 5'h0a;
      3'h7: e = 5'h0b;
      3'h0: e = 5'h00;
    endcase
    return e;
  endfunction : cksd_wd_exp

  always_comb begin
    s_d = s_q;
    s_d.rst_req = 1'b0;
    off = paddr[10:0];
    wb = pwdata[7:0];
    hit = (paddr[31:11] == s_q.base);
    wr = psel && penable && pwrite && s_q.pready && hit;

    // Clock generation: global tick every 2^(sel+1) oscillator cycles in wait
    if (wait_mode && (s_q.div_sel != 3'h0)) begin
      gmask = (9'h002 << s_q.div_sel) - 9'h001;
    end else begin
      gmask = 9'h001;
    end
    hmask = gmask[8:1];
    gtick = ((s_q.slow_cnt & gmask[7:0]) == gmask[7:0]);
    s_d.slow_cnt = s_q.slow_cnt + 8'h01;
    s_d.bus_tick = gtick;
    s_d.fix_tick = s_q.slow_cnt[0];
    // CPU phases step twice per bus period and follow the divided rate
    if ((s_q.slow_cnt & hmask) == hmask) begin
      s_d.cpu_clk = {s_q.cpu_clk[2:0], s_q.cpu_clk[3]};
    end

    // Timers stop in wait or debug when asked to
    run = !(s_q.halt_wait && wait_mode) && !(s_q.halt_dbg && debug_mode);

    // Periodic interrupt timer, clocked by the bus tick
    rexp = (s_q.bypass ? `CKSD_CHAIN_BYP : `CKSD_CHAIN_NORM) + {2'h0, s_q.rti_rate};
    rmask = (20'h00001 << rexp) - 20'h00001;
    if (wr && (off == `CKSD_OFF_RFLG) && wb[`CKSD_RFLG_FLAG]) begin
      s_d.rti_flag = 1'b0;
    end
    if (gtick && run && (s_q.rti_rate != 3'h0)) begin
      s_d.rti_cnt = s_q.rti_cnt + 20'h00001;
      if ((s_q.rti_cnt & rmask) == rmask) begin
        s_d.rti_flag = 1'b1;
      end
    end

    // Watchdog timer
    wexp = (s_q.bypass ? `CKSD_CHAIN_BYP : `CKSD_CHAIN_NORM) + cksd_wd_exp(s_q.wd_rate);
    wmask = (24'h000001 << wexp) - 24'h000001;
    if (gtick && run && (s_q.wd_rate != 3'h0)) begin
      if ((s_q.wd_cnt & wmask) == wmask) begin
        s_d.rst_req = 1'b1;
        s_d.wd_cnt = 24'h000000;
      end else begin
        s_d.wd_cnt = s_q.wd_cnt + 24'h000001;
      end
    end

    // Clock monitor flag from the RC cell is sampled on clock and requests a reset when enabled
    if (s_q.clk_monitor_enable && rc_no_edge) begin
      s_d.rst_req = 1'b1;
    end

    // Register writes
    if (wr) begin
      unique case (off)
        `CKSD_OFF_DIV: s_d.div_sel = wb[2:0];
        `CKSD_OFF_RCTL: begin
          s_d.rti_en = wb[`CKSD_RCTL_EN];
          s_d.rti_rate = wb[2:0];
          if (special_mode || !s_q.hw_lock) begin
            s_d.halt_wait = wb[`CKSD_RCTL_HW];
            s_d.hw_lock = 1'b1;
          end
          if (special_mode || !s_q.hd_lock) begin
            s_d.halt_dbg = wb[`CKSD_RCTL_HD];
            s_d.hd_lock = 1'b1;
          end
          if (special_mode) begin
            s_d.bypass = wb[`CKSD_RCTL_BYP];
          end
        end
        `CKSD_OFF_WCTL: begin
          s_d.clk_monitor_enable = wb[`CKSD_WCTL_CME];
          if (special_mode || !s_q.wd_lock) begin
            s_d.wd_rate = wb[2:0];
            s_d.wd_lock = 1'b1;
            s_d.wd_cnt = 24'h000000;
          end
        end
        `CKSD_OFF_WSVC: begin
          if (wb == `CKSD_SVC_ARM) begin
            s_d.wd_armed = 1'b1;
          end else if (wb == `CKSD_SVC_DONE) begin
            if (s_q.wd_armed) begin
              s_d.wd_cnt = 24'h000000;
            end
            s_d.wd_armed = 1'b0;
          end else begin
            s_d.rst_req = 1'b1;
            s_d.wd_armed = 1'b0;
          end
        end
        `CKSD_OFF_BASE: s_d.base = pwdata[31:11];
        default: begin
        end
      endcase
    end

    s_d.irq = s_d.rti_flag && s_d.rti_en;

    // APB: no wait states, answer registered during setup
    if (psel && !penable) begin
      s_d.pready = 1'b1;
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h00000000;
      if (!hit) begin
        s_d.pslverr = 1'b1;
      end else begin
        unique case (off)
          `CKSD_OFF_DIV: s_d.prdata = {29'h0, s_q.div_sel};
          `CKSD_OFF_RCTL: s_d.prdata = {24'h0, s_q.rti_en, s_q.halt_wait,
                                        s_q.halt_dbg, 1'b0, s_q.bypass, s_q.rti_rate};
          `CKSD_OFF_RFLG: s_d.prdata = {24'h0, s_q.rti_flag, 7'h00};
          `CKSD_OFF_WCTL: s_d.prdata = {24'h0, s_q.clk_monitor_enable, 4'h0, s_q.wd_rate};
          `CKSD_OFF_WSVC: s_d.prdata = 32'h00000000;
          `CKSD_OFF_BASE: s_d.prdata = {s_q.base, 11'h000};
          default: s_d.pslverr = 1'b1;
        endcase
      end
    end else if (psel && penable && s_q.pready) begin
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h00000000;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.base <= `CKSD_BASE_RST;
      s_q.cpu_clk <= 4'h1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // Outputs
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign bus_clk_en = s_q.bus_tick;
  assign wait_fixed_clk_en = s_q.fix_tick;
  assign cpu_clk = s_q.cpu_clk;
  assign periodic_irq = s_q.irq;
  assign sys_reset_req = s_q.rst_req;
endmodule : cksd_top

/* dv/cksd_props.sv */
// Port checker for the clock, periodic interrupt and watchdog slice
`timescale 1ns/1ps
`include "cksd_defines.svh"
module cksd_props (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Monitor and outputs
  input wire logic rc_no_edge,
  input wire logic bus_clk_en,
  input wire logic wait_fixed_clk_en,
  input wire logic [3:0] cpu_clk,
  input wire logic periodic_irq,
  input wire logic sys_reset_req
);
  // ====================
  // Settling counter: the internal reset copy trails resetn by two edges
  logic [2:0] up_q;
  logic acc;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  assign acc = psel && penable && pready && pwrite && !pslverr;
  // ====================
  // Properties
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn || up_q != 3'h7);
  a_fixed_half_rate: assert property (wait_fixed_clk_en != $past(wait_fixed_clk_en))
    else $error("fixed clock enable did not toggle");
  a_cpu_one_hot: assert property ($onehot(cpu_clk))
    else $error("cpu phases not one-hot");
  a_bus_no_pair: assert property (bus_clk_en |=> !bus_clk_en)
    else $error("bus enable pulses back to back");
  a_bad_service: assert property (acc && paddr[10:0] == `CKSD_OFF_WSVC
    && pwdata[7:0] != 8'h55 && pwdata[7:0] != 8'haa |=> sys_reset_req)
    else $error("bad service value gave no reset");
  a_service_reads_zero: assert property (psel && penable && pready && !pwrite
    && paddr[10:0] == `CKSD_OFF_WSVC |-> prdata == 32'h0)
    else $error("service register read not zero");
  a_irq_enable_off: assert property (acc && paddr[10:0] == `CKSD_OFF_RCTL
    && !pwdata[7] |=> ##1 !periodic_irq)
    else $error("irq stayed with enable cleared");
  a_flag_clear_w1c: assert property (acc && paddr[10:0] == `CKSD_OFF_RFLG
    && pwdata[7] |=> ##1 !periodic_irq)
    else $error("irq stayed after flag clear");
  a_reset_one_pulse: assert property (sys_reset_req && !rc_no_edge |=> !sys_reset_req)
    else $error("reset request longer than one cycle");
endmodule : cksd_props

bind cksd_top cksd_props cksd_props_inst (.*);

/* dv/test_clock_slow_divider_rti_watchdog.sv */
// Self-checking bench for the clock slice
`timescale 1ns/1ps
`include "cksd_defines.svh"
module test_clock_slow_divider_rti_watchdog;
  // ====================
  // Signals and design
  logic clock, resetn, psel, penable, pwrite, wait_mode, debug_mode;
  logic special_mode, rc_no_edge, pready, pslverr, bus_clk_en, wait_fixed_clk_en;
  logic periodic_irq, sys_reset_req, erv;
  logic [31:0] paddr, pwdata, prdata, rdv;
  logic [3:0] cpu_clk;
  int n_fail = 0;
  int total_checks = 0;
  int nrst = 0;
  int p;
  cksd_top cksd_top_inst (.*);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) if (sys_reset_req === 1'b1) nrst++;
  // ====================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [10:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {21'h0, a};
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    // Sample the answer mid-cycle, where it is settled, then pass the access edge
    do begin
      @(negedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(n < 50, 1'b1);
    rdv = prdata;
    erv = pslverr;
    @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  // Third gap is measured: the first two may straddle the divider change
  task automatic gap(input logic [2:0] s, input logic wm, input int exp);
    apb(1'b1, `CKSD_OFF_DIV, {5'h0, s});
    wait_mode <= wm;
    repeat (3) begin
      p = 0;
      do begin
        @(posedge clock);
        p++;
      end while (bus_clk_en !== 1'b1 && p < 600);
    end
    chk(p, exp);
  endtask : gap
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // ====================
  // Scenarios
  task automatic t_reset;
    apb(1'b0, `CKSD_OFF_DIV, 8'h0);
    chk(rdv, 32'h0);
    apb(1'b0, `CKSD_OFF_RCTL, 8'h0);
    chk(rdv[2:0], 3'h0);
    apb(1'b0, `CKSD_OFF_RFLG, 8'h0);
    chk(rdv, 32'h0);
    apb(1'b0, 11'h7f0, 8'h0);
    chk(erv, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_div;
    for (int s = 0; s < 8; s++) begin
      gap(s[2:0], 1'b1, (s == 0) ? 2 : 2 << s);
    end
    gap(3'h7, 1'b0, 2);
    $display("divider test done");
  endtask : t_div
  task automatic t_rti;
    special_mode <= 1'b1;
    apb(1'b1, `CKSD_OFF_RCTL, 8'h89);
    p = 0;
    while (periodic_irq !== 1'b1 && p < 40) begin
      @(posedge clock);
      p++;
    end
    chk(p < 14, 1'b1);
    apb(1'b0, `CKSD_OFF_RFLG, 8'h0);
    chk(rdv, 32'h80);
    apb(1'b1, `CKSD_OFF_RCTL, 8'h08);
    @(posedge clock);
    chk(periodic_irq, 1'b0);
    apb(1'b1, `CKSD_OFF_RFLG, 8'h80);
    apb(1'b0, `CKSD_OFF_RFLG, 8'h0);
    chk(rdv, 32'h0);
    wait_mode <= 1'b1;
    apb(1'b1, `CKSD_OFF_RCTL, 8'hc9);
    repeat (40) @(posedge clock);
    apb(1'b0, `CKSD_OFF_RFLG, 8'h0);
    chk(rdv, 32'h0);
    wait_mode <= 1'b0;
    apb(1'b1, `CKSD_OFF_RCTL, 8'h00);
    apb(1'b1, `CKSD_OFF_RFLG, 8'h80);
    special_mode <= 1'b0;
    apb(1'b1, `CKSD_OFF_RCTL, 8'h08);
    apb(1'b0, `CKSD_OFF_RCTL, 8'h0);
    chk(rdv[3], 1'b0);
    $display("periodic test done");
  endtask : t_rti
  task automatic t_wd;
    special_mode <= 1'b1;
    apb(1'b1, `CKSD_OFF_RCTL, 8'h08);
    apb(1'b1, `CKSD_OFF_WCTL, 8'h07);
    nrst = 0;
    repeat (3) begin
      repeat (6000) @(posedge clock);
      apb(1'b1, `CKSD_OFF_WSVC, 8'h55);
      apb(1'b1, `CKSD_OFF_WSVC, 8'haa);
    end
    chk(nrst, 0);
    repeat (8300) @(posedge clock);
    chk(nrst, 1);
    nrst = 0;
    apb(1'b1, `CKSD_OFF_WSVC, 8'h12);
    repeat (2) @(posedge clock);
    chk(nrst, 1);
    apb(1'b1, `CKSD_OFF_WCTL, 8'h01);
    nrst = 0;
    repeat (14) @(posedge clock);
    chk(nrst > 0, 1'b1);
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, `CKSD_OFF_WCTL, c[0] ? 8'h80 : 8'h00);
      nrst = 0;
      rc_no_edge <= 1'b1;
      repeat (4) @(posedge clock);
      rc_no_edge <= 1'b0;
      repeat (2) @(posedge clock);
      chk(nrst > 0, c[0]);
    end
    $display("watchdog test done");
  endtask : t_wd
  // ====================
  // Main sequence and watchdog
  initial begin
    {resetn, psel, penable, pwrite, wait_mode, debug_mode, special_mode, rc_no_edge} = 8'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset;
    t_div;
    t_rti;
    t_wd;
    end_sim;
  end
  initial begin
    #400us;
    n_fail++;
    end_sim;
  end
endmodule : test_clock_slow_divider_rti_watchdog
